/* shared/pbmc_mii_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pbmc_mii_if;
   import pbmc_pkg::*;
   logic loopback, isolate, pdown, col_test;
   logic tx_en;
   logic [NIB_W-1:0] txd;
   logic [NIB_W-1:0] phy_rxd;
   logic phy_rx_dv, phy_col;
   logic [NIB_W-1:0] rxd;
   logic rx_dv, col, oe_n, col_start;
   modport ctl (output loopback, isolate, pdown, col_test, tx_en, txd, phy_rxd,
      phy_rx_dv, phy_col, input rxd, rx_dv, col, oe_n, col_start);
   modport mux (input loopback, isolate, pdown, col_test, tx_en, txd, phy_rxd,
      phy_rx_dv, phy_col, output rxd, rx_dv, col, oe_n, col_start);
endinterface
`default_nettype wire

/* shared/pbmc_pkg.sv */
package pbmc_pkg;
   // Bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int REG_W = 16;
   localparam int NIB_W = 4;
   localparam int BE_LO = 0;
   localparam int BE_HI = 1;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
   // Control field positions
   localparam int B_RESET = 15;
   localparam int B_LOOP = 14;
   localparam int B_SPEED = 13;
   localparam int B_ANEN = 12;
   localparam int B_PDOWN = 11;
   localparam int B_ISO = 10;
   localparam int B_RESTART = 9;
   localparam int B_DUPLEX = 8;
   localparam int B_COLT = 7;
   // Status field positions and fixed values
   localparam int B_ABIL = 15;
   localparam int B_LINK = 2;
   localparam int B_FAULT = 1;
   localparam int CNT_LSB = 4;
   localparam int COR_W = 8;
   localparam logic STAT_ABIL_VAL = 1'b1;
   // Synchroniser lanes
   localparam int SYNC_W = 8;
   localparam int SY_FAULT = 0;
   localparam int SY_LINK = 1;
   localparam int SY_STRAP = 2;
   localparam int SY_TXD = 3;
   localparam int SY_TXEN = 7;
   // Reset sequence length
   localparam int CLK_NS = 100;
   localparam int SRST_TIME_NS = 1000;
   localparam int SRST_CYC = (SRST_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int RCNT_W = 4;
   localparam logic [RCNT_W-1:0] SRST_CNT = RCNT_W'(SRST_CYC);
   typedef enum logic {PBMC_IDLE, PBMC_RESET} pbmc_state_e;
endpackage

/* tb/pbmc_an_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pbmc_an_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic restart,
   output logic started
);
   logic [4:0] cnt;
   // Engine acks a pending restart after a short or long delay
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 5'h00;
         started <= 1'b0;
      end
      else
      begin
         started <= 1'b0;
         if (!restart || started)
            cnt <= 5'h00;
         else if (cnt == (slow ? 5'h1E : 5'h02))
            started <= 1'b1;
         else
            cnt <= cnt + 5'h01;
      end
   end
endmodule // pbmc_an_model
`default_nettype wire

/* tb/pbmc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pbmc_top_assertions
   import pbmc_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic [pbmc_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [pbmc_pkg::DATA_W-1:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic TX_EN,
   input wire logic PHY_COL,
   input wire logic AN_SPEED_100,
   input wire logic AN_FULL_DUPLEX,
   input wire logic AN_STARTED,
   input wire logic [pbmc_pkg::NIB_W-1:0] RXD,
   input wire logic RX_DV,
   input wire logic COL,
   input wire logic MII_OE_N,
   input wire logic SOFT_RESET,
   input wire logic POWER_DOWN,
   input wire logic ISOLATE,
   input wire logic AN_ENABLE,
   input wire logic AN_RESTART,
   input wire logic SPEED_100,
   input wire logic FULL_DUPLEX
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   // Bus: one wait state, ready for one cycle, quiet places read zero
   a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("ready held too long");
   a_req_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request not answered");
   a_rsvd_zero: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == CTRL_OFS
      |-> AVS_READDATA[6:0] == 7'h00)
      else $error("reserved bits not zero");
   a_unmapped_zero: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS != CTRL_OFS
      && AVS_ADDRESS != STAT_OFS |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   // Reset sequence runs its full length before clearing
   a_rst_len: assert property ($fell(SOFT_RESET) |-> $past(SOFT_RESET, 10))
      else $error("reset sequence too short");
   // Gated MII; two cycles allow for the output register
   a_gate_mii: assert property ((POWER_DOWN || ISOLATE) [*2] |-> RXD == 4'h0 && !RX_DV && !COL)
      else $error("MII not gated");
   a_iso_oe: assert property (ISOLATE [*2] |-> MII_OE_N)
      else $error("outputs enabled while isolated");
   a_speed_an: assert property (AN_ENABLE && $past(AN_ENABLE) |-> SPEED_100 == $past(AN_SPEED_100)
      && FULL_DUPLEX == $past(AN_FULL_DUPLEX))
      else $error("forced mode used under negotiation");
   // Restart request: gated, acked, not cancelled by a zero
   a_restart_gate: assert property ($rose(AN_RESTART) |-> AN_ENABLE)
      else $error("restart while negotiation off");
   a_restart_ack: assert property (AN_RESTART && AN_STARTED |=> !AN_RESTART)
      else $error("restart not cleared");
   a_restart_hold: assert property (AN_RESTART && !AN_STARTED && AN_ENABLE && !SOFT_RESET
      |=> AN_RESTART || SOFT_RESET || !AN_ENABLE)
      else $error("restart dropped early");
   // Collision only from the datapath or a recent TX_EN
   a_col_cause: assert property (COL |-> $past(PHY_COL) || $past(TX_EN, 3))
      else $error("collision without cause");
   c_restart: cover property (AN_RESTART && AN_STARTED);
   c_col_test: cover property ($rose(COL) && !$past(PHY_COL));
   c_pdown: cover property (POWER_DOWN [*2]);
endmodule // pbmc_top_assertions
////////////////////////////////////////////////////////////////
bind pbmc_top pbmc_top_assertions pbmc_top_assertions_inst (.MCLK(MCLK), .RESET_N(RESET_N),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_EN(TX_EN),
   .PHY_COL(PHY_COL), .AN_SPEED_100(AN_SPEED_100), .AN_FULL_DUPLEX(AN_FULL_DUPLEX),
   .AN_STARTED(AN_STARTED), .RXD(RXD), .RX_DV(RX_DV), .COL(COL), .MII_OE_N(MII_OE_N),
   .SOFT_RESET(SOFT_RESET), .POWER_DOWN(POWER_DOWN), .ISOLATE(ISOLATE), .AN_ENABLE(AN_ENABLE),
   .AN_RESTART(AN_RESTART), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX));
`default_nettype wire

/* tb/pbmc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pbmc_top_tb_top;
   import pbmc_pkg::*;
   logic clk, rst_n, rd, wr, strap, link, fault, tx_en, prdv, pcol, asp, afd, slow;
   logic wreq, ast, rxdv, col, oen, srst, pdn, iso, anen, anrs, spd, fdx;
   logic [ADDR_W-1:0] adr;
   logic [BE_W-1:0] be;
   logic [DATA_W-1:0] wd, rdat, q;
   logic [NIB_W-1:0] txd, prxd, rxd;
   int err_total, cmp_count, n;
   pbmc_top pbmc_top_inst (.MCLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .STRAP_AN_EN(strap), .LINK_OK(link), .REMOTE_FAULT(fault),
      .TX_EN(tx_en), .TXD(txd), .PHY_RXD(prxd), .PHY_RX_DV(prdv), .PHY_COL(pcol),
      .AN_SPEED_100(asp), .AN_FULL_DUPLEX(afd), .AN_STARTED(ast), .RXD(rxd), .RX_DV(rxdv),
      .COL(col), .MII_OE_N(oen), .SOFT_RESET(srst), .POWER_DOWN(pdn), .ISOLATE(iso),
      .AN_ENABLE(anen), .AN_RESTART(anrs), .SPEED_100(spd), .FULL_DUPLEX(fdx));
   pbmc_an_model pbmc_an_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .restart(anrs),
      .started(ast));
   ////////////////////////////////////////////////////////////////
   // Shared compare, bus cycle and waits
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Request held until ready is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= {16'h0000, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 20)
         chk(32'h0, 32'h1);
   endtask
   // Poll control until the reset bit clears; it must read one first
   task automatic wait_rst();
      int k;
      k = 0;
      do
      begin
         bus(1'b0, CTRL_OFS, 16'h0000);
         k++;
      end
      while (q[B_RESET] !== 1'b0 && k < 20);
      chk(32'(k > 1 && k < 20), 32'h1);
   endtask
   task automatic wait_col(input logic v);
      n = 0;
      do
         @(posedge clk);
      while (col !== v && ++n < 600);
   endtask
   ////////////////////////////////////////////////////////////////
   // Defaults, strap, reserved bits, unmapped place
   task automatic t_reset();
      wait_rst();
      chk(q, 32'(strap) << B_ANEN);
      bus(1'b1, CTRL_OFS, 16'h007F);
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk(q, 32'h0);
      // Low lane only: bit 7 lands, bit 11 in the upper lane must not
      be <= 4'h1;
      bus(1'b1, CTRL_OFS, 16'h0880);
      be <= 4'hF;
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk(q, 32'h0080);
      bus(1'b1, CTRL_OFS, 16'h0000);
      bus(1'b0, 4'h8, 16'h0000);
      chk(q, 32'h0);
   endtask
   // Forced speed and duplex against negotiated ones
   task automatic t_force();
      asp <= 1'b1;
      bus(1'b1, CTRL_OFS, 16'h2100);
      @(negedge clk);
      chk({spd, fdx, anen}, 3'b110);
      bus(1'b1, CTRL_OFS, 16'h0000);
      @(negedge clk);
      chk({spd, fdx}, 2'b00);
      bus(1'b1, CTRL_OFS, 16'h1100);
      @(negedge clk);
      chk({spd, fdx, anen}, 3'b101);
   endtask
   // Restart ignored when off, survives a zero, clears on ack
   task automatic t_restart();
      bus(1'b1, CTRL_OFS, 16'h0200);
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk({q[B_RESTART], anrs}, 2'b00);
      slow <= 1'b1;
      bus(1'b1, CTRL_OFS, 16'h1200);
      bus(1'b1, CTRL_OFS, 16'h1000);
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk({q[B_RESTART], anrs}, 2'b11);
      repeat (40) @(posedge clk);
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk(q, 32'h1000);
      slow <= 1'b0;
      bus(1'b1, CTRL_OFS, 16'h1200);
      repeat (10) @(posedge clk);
      chk(anrs, 1'b0);
   endtask
   // Power down, isolate, then loopback after the dead time
   task automatic t_mii();
      prxd <= 4'hA;
      prdv <= 1'b1;
      bus(1'b1, CTRL_OFS, 16'h0800);
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk({q[15:0], pdn, rxdv, rxd}, {16'h0800, 6'h20});
      bus(1'b1, CTRL_OFS, 16'h0400);
      bus(1'b0, CTRL_OFS, 16'h0000);
      chk({q[15:0], iso, oen, rxdv, rxd}, {16'h0400, 7'h60});
      txd <= 4'h5;
      tx_en <= 1'b1;
      bus(1'b1, CTRL_OFS, 16'h4000);
      repeat (5000) @(posedge clk);
      chk({oen, rxdv, rxd}, 6'h15);
      tx_en <= 1'b0;
      bus(1'b1, CTRL_OFS, 16'h0000);
      repeat (4) @(negedge clk);
      chk({rxdv, rxd}, 5'h1A);
   endtask
   // Collision test; one extra edge for observation lag
   task automatic t_col();
      bus(1'b1, CTRL_OFS, 16'h0080);
      tx_en <= 1'b1;
      wait_col(1'b1);
      chk(32'(n <= 513), 32'h1);
      tx_en <= 1'b0;
      wait_col(1'b0);
      chk(32'(n <= 5), 32'h1);
   endtask
   // Status latches, clear-on-read count, fixed bit
   task automatic t_status();
      // Leave collision test so COL follows the datapath collision
      bus(1'b1, CTRL_OFS, 16'h0000);
      bus(1'b0, STAT_OFS, 16'h0000);
      chk({q[15], q[11:4]}, {STAT_ABIL_VAL, 8'h01});
      bus(1'b0, STAT_OFS, 16'h0000);
      chk(q, 32'h8004);
      link <= 1'b0;
      fault <= 1'b1;
      pcol <= 1'b1;
      repeat (3) @(posedge clk);
      link <= 1'b1;
      fault <= 1'b0;
      pcol <= 1'b0;
      repeat (3) @(posedge clk);
      pcol <= 1'b1;
      repeat (3) @(posedge clk);
      pcol <= 1'b0;
      bus(1'b1, STAT_OFS, 16'h0000);
      bus(1'b0, STAT_OFS, 16'h0000);
      chk(q, 32'h8022);
      bus(1'b0, STAT_OFS, 16'h0000);
      chk(q, 32'h8004);
   endtask
   // Software reset clears bits and reloads the strap
   task automatic t_srst();
      bus(1'b1, CTRL_OFS, 16'hC000);
      @(negedge clk);
      chk(srst, 1'b1);
      wait_rst();
      chk(q, 32'(strap) << B_ANEN);
   endtask
   task automatic give_verdict();
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Watchdog well beyond the roughly 5200 cycles the run needs
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      {rd, wr, tx_en, txd, prxd, prdv, pcol, asp, afd, fault, slow, adr, wd} = '0;
      rst_n = 1'b0;
      be = 4'hF;
      strap = 1'b1;
      link = 1'b1;
      err_total = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_force();
      t_restart();
      t_mii();
      t_col();
      t_status();
      t_srst();
      give_verdict();
   end
endmodule // pbmc_top_tb_top
`default_nettype wire

/* verilog/pbmc_mii.sv */
`timescale 1ns/1ps
`default_nettype none
module pbmc_mii (
   input wire logic clk,
   input wire logic rst_n,
   pbmc_mii_if.mux m
);
   import pbmc_pkg::*;
   typedef struct packed {
      logic [NIB_W-1:0] rxd;
      logic rx_dv;
      logic col;
      logic oe_n;
      logic col_start;
   } pbmc_mii_s;
   pbmc_mii_s r, next_r;
   logic quiet;
   ////////////////////////////////////////////////////////////////////
   // Receive steering, isolation and collision source
   always_comb
   begin
      quiet = m.isolate | m.pdown;
      next_r.rxd = m.loopback ? m.txd : m.phy_rxd;
      next_r.rx_dv = m.loopback ? m.tx_en : m.phy_rx_dv;
      // Test mode follows TX_EN; lag is sync plus one register
      next_r.col = m.col_test ? m.tx_en : m.phy_col;
      if (quiet)
      begin
         next_r.rxd = '0;
         next_r.rx_dv = 1'b0;
         next_r.col = 1'b0;
      end
      next_r.oe_n = m.isolate;
      next_r.col_start = next_r.col & ~r.col;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.oe_n <= 1'b1;
      end
      else
         r <= next_r;
   end
   assign m.rxd = r.rxd;
   assign m.rx_dv = r.rx_dv;
   assign m.col = r.col;
   assign m.oe_n = r.oe_n;
   assign m.col_start = r.col_start;
endmodule // pbmc_mii
`default_nettype wire

/* verilog/pbmc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pbmc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pbmc_sync_s;
   pbmc_sync_s r, next_r;
   // First stage feeds only the second
   always_comb
   begin
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         r <= '0;
      else
         r <= next_r;
   end
   assign q = r.s2;
endmodule // pbmc_sync
`default_nettype wire

/* verilog/pbmc_top.sv */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module pbmc_top (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic [pbmc_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [pbmc_pkg::DATA_W-1:0] AVS_WRITEDATA,
   input wire logic [pbmc_pkg::BE_W-1:0] AVS_BYTEENABLE,
   output logic [pbmc_pkg::DATA_W-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic STRAP_AN_EN,
   input wire logic LINK_OK,
   input wire logic REMOTE_FAULT,
   input wire logic TX_EN,
   input wire logic [pbmc_pkg::NIB_W-1:0] TXD,
   input wire logic [pbmc_pkg::NIB_W-1:0] PHY_RXD,
   input wire logic PHY_RX_DV,
   input wire logic PHY_COL,
   input wire logic AN_SPEED_100,
   input wire logic AN_FULL_DUPLEX,
   input wire logic AN_STARTED,
   output logic [pbmc_pkg::NIB_W-1:0] RXD,
   output logic RX_DV,
   output logic COL,
   output logic MII_OE_N,
   output logic SOFT_RESET,
   output logic POWER_DOWN,
   output logic ISOLATE,
   output logic AN_ENABLE,
   output logic AN_RESTART,
   output logic SPEED_100,
   output logic FULL_DUPLEX
);
   import pbmc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // State

   // Writable control bits, all clear by default except an_en, which reset loads from the strap
   typedef struct packed {
      logic loop;
      logic speed;
      logic an_en;
      logic pdown;
      logic iso;
      logic restart;
      logic duplex;
      logic colt;
   } pbmc_ctrl_s;

   typedef struct packed {
      pbmc_state_e state;
      logic [RCNT_W-1:0] rst_cnt;
      logic waitreq;
      logic [DATA_W-1:0] rdata;
      pbmc_ctrl_s ctl;
      logic link_ll;
      logic fault_lh;
      logic [COR_W-1:0] col_cnt;
      logic soft_rst;
      logic speed_eff;
      logic duplex_eff;
   } pbmc_top_s;

   pbmc_top_s r, next_r;

   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_q;
   logic strap_s, link_s, fault_s;
   logic rd_cap, wr_acc, wr_ctrl, rd_stat;
   logic wr_hi, wr_lo, set_rs;
   logic [REG_W-1:0] ctrl_view;
   logic [REG_W-1:0] stat_view;

   pbmc_mii_if m ();

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // TX_EN, TXD, strap, link and fault pins pass two flops first
   assign sync_in = {TX_EN, TXD, STRAP_AN_EN, LINK_OK, REMOTE_FAULT};

   pbmc_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk(MCLK),
      .rst_n(RESET_N),
      .d(sync_in),
      .q(sync_q)
   );

   assign strap_s = sync_q[SY_STRAP];
   assign link_s = sync_q[SY_LINK];
   assign fault_s = sync_q[SY_FAULT];

   ////////////////////////////////////////////////////////////////////
   // MII steering block

   // Control bits and datapath signals towards the steering block
   assign m.loopback = r.ctl.loop;
   assign m.isolate = r.ctl.iso;
   assign m.pdown = r.ctl.pdown;
   assign m.col_test = r.ctl.colt;
   assign m.tx_en = sync_q[SY_TXEN];
   assign m.txd = sync_q[SY_TXD +: NIB_W];
   assign m.phy_rxd = PHY_RXD;
   assign m.phy_rx_dv = PHY_RX_DV;
   assign m.phy_col = PHY_COL;

   pbmc_mii u_mii (
      .clk(MCLK),
      .rst_n(RESET_N),
      .m(m)
   );

   ////////////////////////////////////////////////////////////////////
   // Register views

   // Control image; reserved low bits are constant zero
   always_comb
   begin
      ctrl_view = '0;
      ctrl_view[B_RESET] = (r.state == PBMC_RESET);
      ctrl_view[B_LOOP] = r.ctl.loop;
      ctrl_view[B_SPEED] = r.ctl.speed;
      ctrl_view[B_ANEN] = r.ctl.an_en;
      ctrl_view[B_PDOWN] = r.ctl.pdown;
      ctrl_view[B_ISO] = r.ctl.iso;
      ctrl_view[B_RESTART] = r.ctl.restart;
      ctrl_view[B_DUPLEX] = r.ctl.duplex;
      ctrl_view[B_COLT] = r.ctl.colt;
   end

   // Status image: latched link, latched fault, collision count
   always_comb
   begin
      stat_view = '0;
      stat_view[B_ABIL] = STAT_ABIL_VAL;
      stat_view[B_LINK] = r.link_ll;
      stat_view[B_FAULT] = r.fault_lh;
      stat_view[CNT_LSB +: COR_W] = r.col_cnt;
   end

   ////////////////////////////////////////////////////////////////////
   // Bus decode

   // One wait state: data captured while waitrequest is high,
   // write committed on the edge that sees it low
   always_comb
   begin
      rd_cap = AVS_READ & r.waitreq;
      wr_acc = AVS_WRITE & ~r.waitreq;
      wr_ctrl = wr_acc & (AVS_ADDRESS == CTRL_OFS);
      wr_hi = wr_ctrl & AVS_BYTEENABLE[BE_HI];
      wr_lo = wr_ctrl & AVS_BYTEENABLE[BE_LO];
      // Side effects tied to the capture cycle, so once per read
      rd_stat = rd_cap & (AVS_ADDRESS == STAT_OFS);
   end

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_r = r;
      set_rs = 1'b0;

      // Waitrequest drops one cycle after a request shows up
      next_r.waitreq = ~((AVS_READ | AVS_WRITE) & r.waitreq);

      // Read data; unmapped offsets answer zero
      if (rd_cap)
      begin
         unique case (AVS_ADDRESS)
            CTRL_OFS: next_r.rdata = DATA_W'(ctrl_view);
            STAT_OFS: next_r.rdata = DATA_W'(stat_view);
            default: next_r.rdata = '0;
         endcase
      end

      // Control register and reset sequence
      unique case (r.state)
         PBMC_IDLE:
         begin
            if (wr_hi && AVS_WRITEDATA[B_RESET])
            begin
               // Software reset: defaults now, strap again at the end
               next_r.state = PBMC_RESET;
               next_r.rst_cnt = SRST_CNT;
               next_r.ctl = '0;
               next_r.ctl.an_en = r.ctl.an_en;
            end
            else
            begin
               if (wr_hi)
               begin
                  next_r.ctl.loop = AVS_WRITEDATA[B_LOOP];
                  next_r.ctl.speed = AVS_WRITEDATA[B_SPEED];
                  next_r.ctl.an_en = AVS_WRITEDATA[B_ANEN];
                  next_r.ctl.pdown = AVS_WRITEDATA[B_PDOWN];
                  next_r.ctl.iso = AVS_WRITEDATA[B_ISO];
                  next_r.ctl.duplex = AVS_WRITEDATA[B_DUPLEX];
               end
               if (wr_lo)
                  next_r.ctl.colt = AVS_WRITEDATA[B_COLT];
               // Restart only counts while negotiation stays enabled
               set_rs = wr_hi & AVS_WRITEDATA[B_RESTART] & next_r.ctl.an_en;
               // A written zero never cancels a pending restart
               // nor touches a running negotiation; request set wins
               next_r.ctl.restart = set_rs
                  | (r.ctl.restart & ~AN_STARTED & next_r.ctl.an_en);
            end
         end
         PBMC_RESET:
         begin
            // Held at defaults; writes are ignored meanwhile
            next_r.ctl = '0;
            next_r.ctl.an_en = r.ctl.an_en;
            if (r.rst_cnt == '0)
            begin
               next_r.state = PBMC_IDLE;
               next_r.ctl.an_en = strap_s;
            end
            else
               next_r.rst_cnt = r.rst_cnt - 1'b1;
         end
      endcase

      // Link: drops on failure, follows live value only after a read
      if (rd_stat)
         next_r.link_ll = link_s;
      else
         next_r.link_ll = r.link_ll & link_s;

      // Fault: a new event beats the read clear
      next_r.fault_lh = fault_s | (r.fault_lh & ~rd_stat);

      // Collision count: a start coinciding with the read survives
      if (rd_stat)
         next_r.col_cnt = COR_W'(m.col_start);
      else if (m.col_start && (r.col_cnt != '1))
         next_r.col_cnt = r.col_cnt + 1'b1;

      // Software reset also clears the status history
      if (next_r.state == PBMC_RESET)
      begin
         next_r.link_ll = 1'b0;
         next_r.fault_lh = 1'b0;
         next_r.col_cnt = '0;
      end

      // Effective mode: negotiation result wins while enabled
      next_r.speed_eff = next_r.ctl.an_en ? AN_SPEED_100 : next_r.ctl.speed;
      next_r.duplex_eff = next_r.ctl.an_en ? AN_FULL_DUPLEX
         : next_r.ctl.duplex;
      next_r.soft_rst = (next_r.state == PBMC_RESET);
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   // Hardware reset runs the same sequence, so the strap is
   // caught by clocked logic after the synchroniser has settled
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         r <= '0;
         r.state <= PBMC_RESET;
         r.rst_cnt <= SRST_CNT;
         r.waitreq <= 1'b1;
         r.soft_rst <= 1'b1;
      end
      else
         r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs, all from flops

   assign AVS_READDATA = r.rdata;
   assign AVS_WAITREQUEST = r.waitreq;
   assign RXD = m.rxd;
   assign RX_DV = m.rx_dv;
   assign COL = m.col;
   assign MII_OE_N = m.oe_n;
   assign SOFT_RESET = r.soft_rst;
   // Datapath must gate itself; this block keeps running
   assign POWER_DOWN = r.ctl.pdown;
   assign ISOLATE = r.ctl.iso;
   assign AN_ENABLE = r.ctl.an_en;
   assign AN_RESTART = r.ctl.restart;
   assign SPEED_100 = r.speed_eff;
   assign FULL_DUPLEX = r.duplex_eff;

endmodule // pbmc_top
`default_nettype wire
